// file: dbg_match_pkg.sv
// package: offsets, field layouts, reset values and helpers of the debug comparator block
package dbg_match_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_UNITS  = 4;
  localparam int CORE_W     = 3;
  localparam int MASK_W     = 8;

  typedef logic [NUM_UNITS-1:0][31:0] word4_type;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFF_WRITE_LOCK  = 8'h04;
  localparam logic [7:0] OFF_DEBUG_IRQ   = 8'h05;
  localparam logic [7:0] OFF_IBP_ADDR    = 8'h30;
  localparam logic [7:0] OFF_IBP_CTRL    = 8'h40;
  localparam logic [7:0] OFF_WP_FIRST    = 8'h50;
  localparam logic [7:0] OFF_WP_SECOND   = 8'h60;
  localparam logic [7:0] OFF_WP_CTRL     = 8'h70;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_ENABLE    = 0;
  localparam int BIT_INVERT    = 1;
  localparam int BIT_LOAD      = 2;
  localparam int MASK_LSB      = 16;
  localparam int BIT_LOCK      = 0;
  localparam int BIT_IRQ_REQ   = 0;
  localparam int BIT_DBG_MODE  = 1;

  // writable bits of each control word, the rest read as zero
  localparam logic [31:0] IBP_CTRL_WMASK = 32'h00ff_0003;
  localparam logic [31:0] WP_CTRL_WMASK  = 32'h00ff_0007;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic        LOCK_RESET      = 1'b0;
  localparam logic        IRQ_REQ_RESET   = 1'b0;
  localparam logic        DBG_MODE_RESET  = 1'b0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

  // mask bit of the given logical core in a control word
  function automatic logic core_enabled(logic [31:0] ctrl, logic [CORE_W-1:0] core);
    core_enabled = ctrl[MASK_LSB + int'(core)];
  endfunction : core_enabled

endpackage : dbg_match_pkg

// file: match_if.sv
// interface: comparator settings and access stream between the register file and comparators
interface match_if;
  dbg_match_pkg::word4_type            ibp_addr;
  dbg_match_pkg::word4_type            ibp_ctrl;
  dbg_match_pkg::word4_type            wp_first;
  dbg_match_pkg::word4_type            wp_second;
  dbg_match_pkg::word4_type            wp_ctrl;
  logic                                pc_valid;
  logic [31:0]                         pc;
  logic [dbg_match_pkg::CORE_W-1:0]    pc_core;
  logic                                mem_valid;
  logic                                mem_store;
  logic [31:0]                         mem_addr;
  logic [dbg_match_pkg::CORE_W-1:0]    mem_core;
  logic [dbg_match_pkg::NUM_UNITS-1:0] ibp_hit;
  logic [dbg_match_pkg::NUM_UNITS-1:0] wp_hit;

  modport owner (output ibp_addr, ibp_ctrl, wp_first, wp_second, wp_ctrl,
                 output pc_valid, pc, pc_core, mem_valid, mem_store, mem_addr, mem_core,
                 input  ibp_hit, wp_hit);
  modport instr (input ibp_addr, ibp_ctrl, pc_valid, pc, pc_core, output ibp_hit);
  modport data  (input wp_first, wp_second, wp_ctrl, mem_valid, mem_store, mem_addr,
                 input mem_core, output wp_hit);
endinterface : match_if

// file: instr_match.sv
// module: four program counter comparators
module instr_match
(
  // settings and program counter stream
  match_if.instr m
);

  always_comb
  begin
    for (int i = 0; i < dbg_match_pkg::NUM_UNITS; i++)
    begin
      logic same;
      logic cond;
      same = (m.pc == m.ibp_addr[i]);
      cond = m.ibp_ctrl[i][dbg_match_pkg::BIT_INVERT] ? !same : same; // RULE_03
      m.ibp_hit[i] = m.pc_valid
                   & m.ibp_ctrl[i][dbg_match_pkg::BIT_ENABLE] // RULE_02
                   & dbg_match_pkg::core_enabled(m.ibp_ctrl[i], m.pc_core) // RULE_01
                   & cond; // RULE_15
    end
  end

endmodule : instr_match

// file: data_match.sv
// module: four load and store address range comparators
module data_match
(
  // settings and memory access stream
  match_if.data m
);

  always_comb
  begin
    for (int i = 0; i < dbg_match_pkg::NUM_UNITS; i++)
    begin
      logic in_range;
      logic out_range;
      logic cond;
      logic kind_ok;
      in_range  = (m.mem_addr >= m.wp_first[i]) && (m.mem_addr <= m.wp_second[i]); // RULE_07
      out_range = (m.mem_addr < m.wp_first[i]) || (m.mem_addr > m.wp_second[i]); // RULE_08
      cond      = m.wp_ctrl[i][dbg_match_pkg::BIT_INVERT] ? out_range : in_range;
      kind_ok = m.mem_store | m.wp_ctrl[i][dbg_match_pkg::BIT_LOAD]; // RULE_09
      m.wp_hit[i] = m.mem_valid
                  & kind_ok
                  & m.wp_ctrl[i][dbg_match_pkg::BIT_ENABLE] // RULE_02
                  & dbg_match_pkg::core_enabled(m.wp_ctrl[i], m.mem_core) // RULE_01
                  & cond; // RULE_15
    end
  end

endmodule : data_match

// file: debug_breakpoint_watchpoint_unit.sv
// top: debug breakpoint and watchpoint registers, comparators and debug interrupt request
//
// Function
// RULE_01 - each comparator fires only for logical cores whose eight-bit mask bit is set
// RULE_02 - control bit 0 enables a comparator; cleared means never fire; resets zero
// RULE_03 - breakpoint fires on pc equal address, or on unequal when bit 1 set
// RULE_04 - an enabled breakpoint hit on a selected core raises a debug interrupt there
// RULE_05 - four breakpoint control words with mask, invert and enable, all reset zero
// RULE_06 - four watchpoints each with writable 32-bit first and second addresses
// RULE_07 - bit 1 clear: watchpoint fires on addresses from first to second inclusive
// RULE_08 - bit 1 set: watchpoint fires strictly outside the range, never at the ends
// RULE_09 - stores always considered; loads only with control bit 2 set, reset zero
// RULE_10 - four watchpoint control words with mask, load enable, invert and enable
// RULE_11 - lock bit 0 makes config-writable registers read-only from the switch side
// RULE_12 - writing one to debug interrupt bit 0 requests a debug interrupt; resets zero
// RULE_13 - debug interrupt bit 1 is read-only and shows debug mode; resets zero
// RULE_14 - reserved bits of all control words are read-only and read zero
// RULE_15 - fire only when enable, core mask bit and address condition hold together
module debug_breakpoint_watchpoint_unit
(
  // clock and reset
  input  wire logic                              clock,
  input  wire logic                              rst_n,

  // debugger register port, reaches debug and configuration registers
  input  wire logic [7:0]                        dbg_addr,
  input  wire logic                              dbg_write,
  input  wire logic [31:0]                       dbg_wdata,
  output logic      [31:0]                       dbg_rdata,

  // processor switch register port, configuration registers only
  input  wire logic [7:0]                        switch_addr,
  input  wire logic                              switch_write,
  input  wire logic [31:0]                       switch_wdata,
  output logic      [31:0]                       switch_rdata,

  // pipeline instruction stream
  input  wire logic                              pc_valid,
  input  wire logic [31:0]                       program_counter,
  input  wire logic [dbg_match_pkg::CORE_W-1:0]  pc_core,

  // pipeline memory access stream
  input  wire logic                              mem_valid,
  input  wire logic                              mem_store,
  input  wire logic [31:0]                       mem_addr,
  input  wire logic [dbg_match_pkg::CORE_W-1:0]  mem_core,

  // processor state
  input  wire logic                              debug_mode,

  // debug events toward the pipeline
  output logic [dbg_match_pkg::NUM_UNITS-1:0]    ibp_hit,
  output logic [dbg_match_pkg::CORE_W-1:0]       ibp_core,
  output logic [dbg_match_pkg::NUM_UNITS-1:0]    wp_hit,
  output logic [dbg_match_pkg::CORE_W-1:0]       wp_core,
  output logic                                   debug_irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                                 lock;
    logic                                 irq_req;
    logic                                 dbg_mode;
    dbg_match_pkg::word4_type             ibp_addr;
    dbg_match_pkg::word4_type             ibp_ctrl;
    dbg_match_pkg::word4_type             wp_first;
    dbg_match_pkg::word4_type             wp_second;
    dbg_match_pkg::word4_type             wp_ctrl;
    logic [31:0]                          dbg_rdata;
    logic [31:0]                          switch_rdata;
    logic [dbg_match_pkg::NUM_UNITS-1:0]  ibp_hit;
    logic [dbg_match_pkg::CORE_W-1:0]     ibp_core;
    logic [dbg_match_pkg::NUM_UNITS-1:0]  wp_hit;
    logic [dbg_match_pkg::CORE_W-1:0]     wp_core;
    logic                                 debug_irq;
  } state_type;

  state_type s;
  state_type next_s;

  match_if m ();

  // ****************************************
  // comparators
  // ****************************************
  instr_match u_instr_match
  (
    .m (m.instr)
  );

  data_match u_data_match
  (
    .m (m.data)
  );

  assign m.ibp_addr  = s.ibp_addr;
  assign m.ibp_ctrl  = s.ibp_ctrl;
  assign m.wp_first  = s.wp_first;
  assign m.wp_second = s.wp_second;
  assign m.wp_ctrl   = s.wp_ctrl;
  assign m.pc_valid  = pc_valid;
  assign m.pc        = program_counter;
  assign m.pc_core   = pc_core;
  assign m.mem_valid = mem_valid;
  assign m.mem_store = mem_store;
  assign m.mem_addr  = mem_addr;
  assign m.mem_core  = mem_core;

  // ****************************************
  // register access helpers
  // ****************************************
  // configuration space holds the lock and the debug interrupt word
  function automatic state_type write_reg(state_type st, logic [7:0] a, logic [31:0] d,
                                          logic cfg_only);
    logic [1:0] i;
    i = a[1:0];
    write_reg = st;
    if (a == dbg_match_pkg::OFF_WRITE_LOCK)
    begin
      write_reg.lock = d[dbg_match_pkg::BIT_LOCK];
    end
    else if (a == dbg_match_pkg::OFF_DEBUG_IRQ)
    begin
      write_reg.irq_req = d[dbg_match_pkg::BIT_IRQ_REQ]; // RULE_12
    end
    else if (!cfg_only)
    begin
      case (a[7:2])
        dbg_match_pkg::OFF_IBP_ADDR[7:2]:
          write_reg.ibp_addr[i] = d;
        dbg_match_pkg::OFF_IBP_CTRL[7:2]:
          write_reg.ibp_ctrl[i] = d & dbg_match_pkg::IBP_CTRL_WMASK; // RULE_05 RULE_14
        dbg_match_pkg::OFF_WP_FIRST[7:2]:
          write_reg.wp_first[i] = d; // RULE_06
        dbg_match_pkg::OFF_WP_SECOND[7:2]:
          write_reg.wp_second[i] = d; // RULE_06
        dbg_match_pkg::OFF_WP_CTRL[7:2]:
          write_reg.wp_ctrl[i] = d & dbg_match_pkg::WP_CTRL_WMASK; // RULE_10 RULE_14
        default:
          write_reg = st;
      endcase
    end
  endfunction : write_reg

  function automatic logic [31:0] read_reg(state_type st, logic [7:0] a, logic cfg_only);
    logic [1:0] i;
    i = a[1:0];
    read_reg = 32'h0000_0000;
    if (a == dbg_match_pkg::OFF_WRITE_LOCK)
    begin
      read_reg[dbg_match_pkg::BIT_LOCK] = st.lock;
    end
    else if (a == dbg_match_pkg::OFF_DEBUG_IRQ)
    begin
      read_reg[dbg_match_pkg::BIT_IRQ_REQ]  = st.irq_req;
      read_reg[dbg_match_pkg::BIT_DBG_MODE] = st.dbg_mode; // RULE_13
    end
    else if (!cfg_only)
    begin
      case (a[7:2])
        dbg_match_pkg::OFF_IBP_ADDR[7:2]:
          read_reg = st.ibp_addr[i];
        dbg_match_pkg::OFF_IBP_CTRL[7:2]:
          read_reg = st.ibp_ctrl[i];
        dbg_match_pkg::OFF_WP_FIRST[7:2]:
          read_reg = st.wp_first[i];
        dbg_match_pkg::OFF_WP_SECOND[7:2]:
          read_reg = st.wp_second[i];
        dbg_match_pkg::OFF_WP_CTRL[7:2]:
          read_reg = st.wp_ctrl[i];
        default:
          read_reg = 32'h0000_0000;
      endcase
    end
  endfunction : read_reg

  // true when any comparator of the group fired
  function automatic logic any_hit(logic [dbg_match_pkg::NUM_UNITS-1:0] h);
    any_hit = |h;
  endfunction : any_hit

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_s = s;

    // switch writes are dropped while locked; debugger writes win on a collision
    if (switch_write && !s.lock) // RULE_11
    begin
      next_s = write_reg(next_s, switch_addr, switch_wdata, 1'b1);
    end
    if (dbg_write)
    begin
      next_s = write_reg(next_s, dbg_addr, dbg_wdata, 1'b0);
    end

    next_s.dbg_mode     = debug_mode; // RULE_13
    next_s.dbg_rdata    = read_reg(s, dbg_addr, 1'b0);
    next_s.switch_rdata = read_reg(s, switch_addr, 1'b1);

    // hits, each reported with the core that caused it
    next_s.ibp_hit  = m.ibp_hit; // RULE_15
    next_s.ibp_core = any_hit(m.ibp_hit) ? pc_core : s.ibp_core; // RULE_04
    next_s.wp_hit   = m.wp_hit;
    next_s.wp_core  = any_hit(m.wp_hit) ? mem_core : s.wp_core;

    // software request or breakpoint hit both reach the debug interrupt
    next_s.debug_irq = next_s.irq_req | any_hit(m.ibp_hit); // RULE_04 RULE_12
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s.lock         <= dbg_match_pkg::LOCK_RESET;
      s.irq_req      <= dbg_match_pkg::IRQ_REQ_RESET; // RULE_12
      s.dbg_mode     <= dbg_match_pkg::DBG_MODE_RESET; // RULE_13
      s.ibp_addr     <= {dbg_match_pkg::NUM_UNITS{dbg_match_pkg::ADDR_RESET}};
      s.ibp_ctrl     <= {dbg_match_pkg::NUM_UNITS{dbg_match_pkg::CTRL_RESET}}; // RULE_02 RULE_05
      s.wp_first     <= {dbg_match_pkg::NUM_UNITS{dbg_match_pkg::ADDR_RESET}};
      s.wp_second    <= {dbg_match_pkg::NUM_UNITS{dbg_match_pkg::ADDR_RESET}};
      s.wp_ctrl      <= {dbg_match_pkg::NUM_UNITS{dbg_match_pkg::CTRL_RESET}}; // RULE_09
      s.dbg_rdata    <= dbg_match_pkg::RDATA_RESET;
      s.switch_rdata <= dbg_match_pkg::RDATA_RESET;
      s.ibp_hit      <= '0;
      s.ibp_core     <= '0;
      s.wp_hit       <= '0;
      s.wp_core      <= '0;
      s.debug_irq    <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dbg_rdata    = s.dbg_rdata;
  assign switch_rdata = s.switch_rdata;
  assign ibp_hit      = s.ibp_hit;
  assign ibp_core     = s.ibp_core;
  assign wp_hit       = s.wp_hit;
  assign wp_core      = s.wp_core;
  assign debug_irq    = s.debug_irq;

endmodule : debug_breakpoint_watchpoint_unit

// file: dbg_unit_monitor.sv
// checker: timing and field relations at the debug comparator block ports
module dbg_unit_monitor
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // register ports
  input wire logic [7:0]  dbg_addr,
  input wire logic        dbg_write,
  input wire logic [31:0] dbg_wdata,
  input wire logic [31:0] dbg_rdata,
  input wire logic [7:0]  switch_addr,
  input wire logic [31:0] switch_rdata,
  // pipeline streams and events
  input wire logic        pc_valid,
  input wire logic [2:0]  pc_core,
  input wire logic        mem_valid,
  input wire logic [2:0]  mem_core,
  input wire logic        debug_mode,
  input wire logic [3:0]  ibp_hit,
  input wire logic [2:0]  ibp_core,
  input wire logic [3:0]  wp_hit,
  input wire logic [2:0]  wp_core,
  input wire logic        debug_irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // properties
  // ****************************************
  property p_irq_req;
    dbg_write && dbg_addr == 8'h05 && dbg_wdata[0] |-> ##[1:2] debug_irq;
  endproperty
  a_irq_req: assert property (p_irq_req) else $error("request bit gave no irq");
  property p_hit_irq;
    (ibp_hit != 4'h0) |-> debug_irq;
  endproperty
  a_hit_irq: assert property (p_hit_irq) else $error("breakpoint hit without irq");
  property p_ibp_idle;
    !pc_valid |=> ibp_hit == 4'h0;
  endproperty
  a_ibp_idle: assert property (p_ibp_idle) else $error("breakpoint hit with no fetch");
  property p_wp_idle;
    !mem_valid |=> wp_hit == 4'h0;
  endproperty
  a_wp_idle: assert property (p_wp_idle) else $error("watchpoint hit with no access");
  property p_ibp_core;
    pc_valid |=> (ibp_hit == 4'h0 || ibp_core == $past(pc_core));
  endproperty
  a_ibp_core: assert property (p_ibp_core) else $error("wrong breakpoint core");
  property p_wp_core;
    mem_valid |=> (wp_hit == 4'h0 || wp_core == $past(mem_core));
  endproperty
  a_wp_core: assert property (p_wp_core) else $error("wrong watchpoint core");
  property p_mode;
    dbg_addr == 8'h05 && $stable(debug_mode) |=> dbg_rdata[1] == $past(debug_mode);
  endproperty
  a_mode: assert property (p_mode) else $error("debug mode bit wrong");
  property p_ibp_rsv;
    dbg_addr[7:2] == 6'h10 |=> (dbg_rdata & ~dbg_match_pkg::IBP_CTRL_WMASK) == 32'h0;
  endproperty
  a_ibp_rsv: assert property (p_ibp_rsv) else $error("breakpoint reserved bits set");
  property p_wp_rsv;
    dbg_addr[7:2] == 6'h1c |=> (dbg_rdata & ~dbg_match_pkg::WP_CTRL_WMASK) == 32'h0;
  endproperty
  a_wp_rsv: assert property (p_wp_rsv) else $error("watchpoint reserved bits set");
  property p_cfg_rsv;
    dbg_addr[7:1] == 7'h02 |=> dbg_rdata[31:2] == 30'h0;
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("config reserved bits set");
  property p_sw_space;
    !(switch_addr inside {8'h04, 8'h05}) |=> switch_rdata == 32'h0;
  endproperty
  a_sw_space: assert property (p_sw_space) else $error("switch reached debug space");
  c_ibp: cover property (ibp_hit != 4'h0);
  c_wp: cover property (wp_hit != 4'h0);
  c_irq: cover property (debug_irq && ibp_hit == 4'h0);
endmodule : dbg_unit_monitor

bind debug_breakpoint_watchpoint_unit dbg_unit_monitor u_dbg_unit_monitor
(
  .clock(clock), .rst_n(rst_n), .dbg_addr(dbg_addr), .dbg_write(dbg_write),
  .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata), .switch_addr(switch_addr),
  .switch_rdata(switch_rdata), .pc_valid(pc_valid), .pc_core(pc_core),
  .mem_valid(mem_valid), .mem_core(mem_core), .debug_mode(debug_mode),
  .ibp_hit(ibp_hit), .ibp_core(ibp_core), .wp_hit(wp_hit), .wp_core(wp_core),
  .debug_irq(debug_irq)
);

// file: pipe_model.sv
// partner: pipeline side issuing fetches and memory accesses
module pipe_model
(
  // clock
  input wire logic    clock,
  // streams toward the block
  output logic        pc_valid,
  output logic [31:0] program_counter,
  output logic [2:0]  pc_core,
  output logic        mem_valid,
  output logic        mem_store,
  output logic [31:0] mem_addr,
  output logic [2:0]  mem_core,
  output logic        debug_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {pc_valid, program_counter, pc_core, debug_mode} = '0;
    {mem_valid, mem_store, mem_addr, mem_core} = '0;
  end
  // idle cycles show inverted values so stale data never looks valid
  task automatic issue_pc(input logic [31:0] a, input logic [2:0] c);
    @(posedge clock);
    {pc_valid, program_counter, pc_core} <= {1'b1, a, c};
    @(posedge clock);
    {pc_valid, program_counter, pc_core} <= {1'b0, ~a, ~c};
  endtask : issue_pc
  task automatic issue_mem(input logic s, input logic [31:0] a, input logic [2:0] c);
    @(posedge clock);
    {mem_valid, mem_store, mem_addr, mem_core} <= {1'b1, s, a, c};
    @(posedge clock);
    {mem_valid, mem_store, mem_addr, mem_core} <= {1'b0, ~s, ~a, ~c};
  endtask : issue_mem
  task automatic set_mode(input logic m);
    @(posedge clock);
    debug_mode <= m;
  endtask : set_mode
endmodule : pipe_model

// file: tb_top.sv
// testbench: registers, comparators and lock against a behavioural model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        dbg_write = 1'b0;
  logic        switch_write = 1'b0;
  logic [31:0] dbg_rdata, switch_rdata, program_counter, mem_addr;
  logic        pc_valid, mem_valid, mem_store, debug_mode, debug_irq;
  logic [2:0]  pc_core, mem_core, ibp_core, wp_core;
  logic [3:0]  ibp_hit, wp_hit;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [31:0] ia[4] = '{default: 32'h0};
  logic [31:0] ic[4] = '{default: 32'h0};
  logic [31:0] wf[4] = '{default: 32'h0};
  logic [31:0] ws[4] = '{default: 32'h0};
  logic [31:0] wc[4] = '{default: 32'h0};
  logic        lock = 1'b0;
  logic        irq = 1'b0;
  logic [7:0]  offs[6] = '{8'h04, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70};
  logic [31:0] p;
  always #5 clock = ~clock;
  debug_breakpoint_watchpoint_unit u_debug_breakpoint_watchpoint_unit
  (
    .clock(clock), .rst_n(rst_n), .dbg_addr(addr), .dbg_write(dbg_write),
    .dbg_wdata(wdata), .dbg_rdata(dbg_rdata), .switch_addr(addr),
    .switch_write(switch_write), .switch_wdata(wdata), .switch_rdata(switch_rdata),
    .pc_valid(pc_valid), .program_counter(program_counter), .pc_core(pc_core),
    .mem_valid(mem_valid), .mem_store(mem_store), .mem_addr(mem_addr),
    .mem_core(mem_core), .debug_mode(debug_mode), .ibp_hit(ibp_hit),
    .ibp_core(ibp_core), .wp_hit(wp_hit), .wp_core(wp_core), .debug_irq(debug_irq)
  );
  pipe_model u_pipe_model
  (
    .clock(clock), .pc_valid(pc_valid), .program_counter(program_counter),
    .pc_core(pc_core), .mem_valid(mem_valid), .mem_store(mem_store),
    .mem_addr(mem_addr), .mem_core(mem_core), .debug_mode(debug_mode)
  );
  // ****************************************
  // model and shared tasks
  // ****************************************
  function automatic logic [31:0] mdl_rd(input bit sw, input logic [7:0] a);
    if (sw && a[7:1] != 7'h02) return 32'h0;
    if (a == 8'h04) return {31'h0, lock};
    if (a == 8'h05) return {30'h0, debug_mode, irq};
    case (a[7:2])
      6'h0c: return ia[a[1:0]];
      6'h10: return ic[a[1:0]];
      6'h14: return wf[a[1:0]];
      6'h18: return ws[a[1:0]];
      6'h1c: return wc[a[1:0]];
      default: return 32'h0;
    endcase
  endfunction : mdl_rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input bit sw, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {addr, wdata, dbg_write, switch_write} <= {a, d, !sw, sw};
    @(posedge clock);
    {dbg_write, switch_write} <= 2'b00;
    if (sw && (lock || a[7:1] != 7'h02)) return;
    if (a == 8'h04) lock = d[0];
    if (a == 8'h05) irq = d[0];
    case (a[7:2])
      6'h0c: ia[a[1:0]] = d;
      6'h10: ic[a[1:0]] = d & dbg_match_pkg::IBP_CTRL_WMASK;
      6'h14: wf[a[1:0]] = d;
      6'h18: ws[a[1:0]] = d;
      6'h1c: wc[a[1:0]] = d & dbg_match_pkg::WP_CTRL_WMASK;
      default: ;
    endcase
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    repeat (2) @(posedge clock);
    #1;
    chk("dbg_rdata", mdl_rd(0, a), dbg_rdata);
    chk("switch_rdata", mdl_rd(1, a), switch_rdata);
  endtask : rd
  task automatic pc_test(input logic [31:0] a, input logic [2:0] c);
    logic [3:0] e;
    for (int i = 0; i < 4; i++)
      e[i] = ic[i][0] && ic[i][16+c] && ((a == ia[i]) != ic[i][1]);
    u_pipe_model.issue_pc(a, c);
    #1;
    chk("ibp_hit", {28'h0, e}, {28'h0, ibp_hit});
    chk("debug_irq", {31'h0, irq | (|e)}, {31'h0, debug_irq});
    if (e != 4'h0) chk("ibp_core", {29'h0, c}, {29'h0, ibp_core});
  endtask : pc_test
  task automatic mem_test(input logic s, input logic [31:0] a, input logic [2:0] c);
    logic [3:0] e;
    for (int i = 0; i < 4; i++)
      e[i] = wc[i][0] && wc[i][16+c] && (s || wc[i][2])
        && (wc[i][1] ? (a < wf[i] || a > ws[i]) : (a >= wf[i] && a <= ws[i]));
    u_pipe_model.issue_mem(s, a, c);
    #1;
    chk("wp_hit", {28'h0, e}, {28'h0, wp_hit});
    if (e != 4'h0) chk("wp_core", {29'h0, c}, {29'h0, wp_core});
  endtask : mem_test
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    #100us;
    bad_count++;
    end_sim();
  end
  initial
  begin
    void'($urandom(39));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    foreach (offs[k]) for (int j = 0; j < 4; j++) rd(8'(offs[k] + j));
    $display("test reset_values finished");
    for (int k = 1; k < 6; k++) for (int j = 0; j < 4; j++) wr(0, 8'(offs[k] + j), $urandom);
    foreach (offs[k]) for (int j = 0; j < 4; j++) rd(8'(offs[k] + j));
    $display("test register_access finished");
    for (int n = 0; n < 120; n++)
    begin
      if (n % 8 == 0) wr(0, 8'(8'h40 + (n / 8) % 4), $urandom);
      p = ($urandom % 2) ? ia[$urandom % 4] : $urandom;
      pc_test(p, 3'($urandom));
    end
    $display("test breakpoints finished");
    for (int j = 0; j < 4; j++) wr(0, 8'(8'h60 + j), wf[j] + 32'h10);
    for (int n = 0; n < 160; n++)
    begin
      if (n % 8 == 0) wr(0, 8'(8'h70 + (n / 8) % 4), $urandom);
      p = wf[$urandom % 4] + ($urandom % 19) - 32'h1;
      mem_test(1'($urandom), p, 3'($urandom));
    end
    $display("test watchpoints finished");
    wr(1, 8'h05, 32'h1);
    pc_test(ia[0], 3'h0);
    wr(1, 8'h05, 32'h0);
    wr(1, 8'h04, 32'hffff_ffff);
    wr(1, 8'h04, 32'h0);
    rd(8'h04);
    wr(1, 8'h05, 32'h1);
    wr(1, 8'h40, 32'h00ff_0003);
    rd(8'h05);
    rd(8'h40);
    wr(0, 8'h05, 32'h1);
    u_pipe_model.set_mode(1'b1);
    rd(8'h05);
    u_pipe_model.set_mode(1'b0);
    wr(0, 8'h04, 32'h0);
    wr(1, 8'h05, 32'h0);
    rd(8'h05);
    wr(0, 8'h41, 32'h0002_0001);
    pc_test(ia[1], 3'h1);
    $display("test lock_and_request finished");
    end_sim();
  end
endmodule : tb_top
